// [src/ecg_pkg.sv]
/*
 * ecg_pkg: constants shared by the electrochromic glass control block:
 * register offsets, field positions, reset values and filter timing.
 * Assumes a 25 MHz system clock and a plain strobe register port.
 */
package ecg_pkg;
	localparam int unsigned CLK_HZ = 25_000_000;

	// register offsets (word index on the plain port)
	localparam logic [3:0] OFS_CTRL   = 4'h0; // enable, discharge, range, target
	localparam logic [3:0] OFS_SUPCFG = 4'h1; // supply output settings, shutdown enables
	localparam logic [3:0] OFS_STAT   = 4'h2; // live loop state, read only
	localparam logic [3:0] OFS_IRQ    = 4'h3; // sticky events, write one to clear
	localparam logic [3:0] OFS_MASK   = 4'h4; // interrupt mask
	localparam logic [3:0] OFS_FAIL   = 4'h5; // supply failure latch, read and clear

	// control register fields
	localparam int unsigned CTRL_CODE_LSB = 0;  // six bit target code
	localparam int unsigned CTRL_EN_BIT   = 8;
	localparam int unsigned CTRL_LS_BIT   = 9;
	localparam int unsigned CTRL_HV_BIT   = 10;
	localparam logic [15:0] CTRL_RST      = 16'h0000;

	// supply configuration fields
	localparam int unsigned SUP_ON_BIT    = 0;  // own on/off setting
	localparam int unsigned SUP_PWM_BIT   = 1;  // own pwm select
	localparam int unsigned SUP_DIR_BIT   = 2;
	localparam int unsigned SUP_TMR_LSB   = 3;  // two timer select bits
	localparam int unsigned SUP_OVSD_BIT  = 5;
	localparam int unsigned SUP_UVSD_BIT  = 6;
	localparam int unsigned SUP_LOCK_BIT  = 7;
	localparam logic [7:0]  SUPCFG_RST    = 8'h80;

	// event bits in status, mask and sticky registers
	localparam int unsigned EV_ABOVE = 0;
	localparam int unsigned EV_BELOW = 1;
	localparam int unsigned EV_FAIL  = 2;
	localparam int unsigned EV_W     = 3;

	// full scale and clamp, in millivolts; one code step is 1500/64 mV
	localparam int unsigned FULL_SCALE_MV = 1500;
	localparam int unsigned CLAMP_MV      = 1200;
	localparam logic [5:0]  CLAMP_CODE    = 6'(CLAMP_MV * 64 / FULL_SCALE_MV);

	// comparator filter times in microseconds, then in cycles (rounded down, at least one)
	localparam int unsigned ABOVE_FILTER_US = 64;
	localparam int unsigned BELOW_FILTER_US = 64;
	localparam int unsigned ABOVE_FILTER_CYC =
		(ABOVE_FILTER_US * (CLK_HZ / 1_000_000) > 0) ? ABOVE_FILTER_US * (CLK_HZ / 1_000_000) : 1;
	localparam int unsigned BELOW_FILTER_CYC =
		(BELOW_FILTER_US * (CLK_HZ / 1_000_000) > 0) ? BELOW_FILTER_US * (CLK_HZ / 1_000_000) : 1;
	localparam int unsigned FILT_W = 12;
endpackage : ecg_pkg

// [src/ecg_cmp_if.sv]
/*
 * ecg_cmp_if: carries one raw comparator level into a filter and the
 * settled flag back out. Assumes one shared clock domain.
 */
interface ecg_cmp_if;
	logic raw;
	logic flag;
	logic rise;
	modport filt (input raw, output flag, output rise);
	modport user (output raw, input flag, input rise);
endinterface : ecg_cmp_if

// [src/ecg_filter.sv]
/*
 * ecg_filter: stability filter for one comparator level; the flag follows
 * the raw level only after it has stood unchanged for CYCLES clocks.
 * Assumes the raw level is synchronous to sys_clk.
 */
module ecg_filter #(
	parameter int unsigned CYCLES = 1
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	ecg_cmp_if.filt   cmp
);
	typedef struct packed {
		logic [ecg_pkg::FILT_W-1:0] cnt;
		logic                       flag;
		logic                       rise;
	} ecg_filt_s;

	ecg_filt_s st_q;
	ecg_filt_s st_d;

	localparam logic [ecg_pkg::FILT_W-1:0] LAST = ecg_pkg::FILT_W'(CYCLES - 1);

	// count while the level differs from the flag; any bounce restarts the wait
	always_comb begin
		st_d      = st_q;
		st_d.rise = 1'b0;
		if (cmp.raw == st_q.flag) begin
			st_d.cnt = '0;
		end else if (st_q.cnt >= LAST) begin
			st_d.cnt  = '0;
			st_d.flag = cmp.raw;
			st_d.rise = cmp.raw;
		end else begin
			st_d.cnt = st_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign cmp.flag = st_q.flag;
	assign cmp.rise = st_q.rise;
endmodule : ecg_filter

// [src/ecg_ctrl.sv]
/*
 * ecg_ctrl: digital control and supervision of the electrochromic glass
 * voltage loop: target code and clamp, fast discharge, filtered loop
 * flags, takeover of the supply high-side output, failure and restart.
 * Assumes analog comparators and fault detectors deliver levels
 * synchronous to sys_clk, and a register master that never waits.
 */
module ecg_ctrl (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// analog loop comparators and supply supervision
	input  wire logic        cmp_above,
	input  wire logic        cmp_below,
	input  wire logic        cmp_within_margin,
	input  wire logic        sup_overcurrent,
	input  wire logic        sup_overvoltage,
	input  wire logic        sup_undervoltage,
	input  wire logic        thermal_shutdown_level_one,
	input  wire logic        sup_pwm_in,
	// analog loop controls
	output logic      [5:0]  glass_dac_code,
	output logic             loop_enable,
	output logic             fast_discharge_switch_on,
	output logic             gate_pin_discharge_on,
	output logic             gate_pin_hard_ground,
	output logic             glass_supply_output,
	output logic             above_target_flag,
	output logic             below_target_flag,
	output logic             irq
);
	typedef struct packed {
		logic [5:0]                glass_target_code;
		logic                      glass_control_enable;
		logic                      fast_discharge_sel;
		logic                      high_voltage_range_select;
		logic [7:0]                supcfg;
		logic                      failed;
		logic                      ls_active;
		logic [ecg_pkg::EV_W-1:0]  sticky;
		logic [ecg_pkg::EV_W-1:0]  mask;
		logic [31:0]               rdata;
		logic [5:0]                dac;
		logic                      loop_en;
		logic                      ls_out;
		logic                      gate_res;
		logic                      gate_gnd;
		logic                      sup_out;
		logic                      above;
		logic                      below;
		logic                      irq;
	} ecg_ctrl_s;

	ecg_ctrl_s st_q;
	ecg_ctrl_s st_d;

	ecg_cmp_if above_if ();
	ecg_cmp_if below_if ();

	assign above_if.raw = cmp_above;
	assign below_if.raw = cmp_below;

	// the above and below comparators each get their own filter time; the margin comparator is not filtered
	ecg_filter #(.CYCLES(ecg_pkg::ABOVE_FILTER_CYC)) u_above_filt (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.cmp     (above_if.filt)
	);
	ecg_filter #(.CYCLES(ecg_pkg::BELOW_FILTER_CYC)) u_below_filt (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.cmp     (below_if.filt)
	);

	// clamp the code when the high range is not selected; step size is unchanged
	function automatic logic [5:0] clamp_code(input logic [5:0] code, input logic hv);
		if (!hv && code > ecg_pkg::CLAMP_CODE) begin
			clamp_code = ecg_pkg::CLAMP_CODE;
		end else begin
			clamp_code = code;
		end
	endfunction : clamp_code

	// register read image for one offset
	function automatic logic [31:0] read_word(input ecg_ctrl_s s, input logic [3:0] a,
	                                          input logic af, input logic bf);
		read_word = 32'h0000_0000;
		case (a)
			ecg_pkg::OFS_CTRL: begin
				read_word[ecg_pkg::CTRL_CODE_LSB +: 6] = s.glass_target_code;
				read_word[ecg_pkg::CTRL_EN_BIT]        = s.glass_control_enable;
				read_word[ecg_pkg::CTRL_LS_BIT]        = s.fast_discharge_sel;
				read_word[ecg_pkg::CTRL_HV_BIT]        = s.high_voltage_range_select;
			end
			ecg_pkg::OFS_SUPCFG: read_word[7:0] = s.supcfg;
			ecg_pkg::OFS_STAT: begin
				read_word[ecg_pkg::EV_ABOVE] = af;
				read_word[ecg_pkg::EV_BELOW] = bf;
				read_word[ecg_pkg::EV_FAIL]  = s.failed;
			end
			ecg_pkg::OFS_IRQ:  read_word[ecg_pkg::EV_W-1:0] = s.sticky;
			ecg_pkg::OFS_MASK: read_word[ecg_pkg::EV_W-1:0] = s.mask;
			ecg_pkg::OFS_FAIL: read_word[0] = s.failed;
			default:           read_word = 32'h0000_0000; // unmapped reads as zero
		endcase
	endfunction : read_word

	logic sup_fault;
	logic glass_mode;
	logic own_output;

	always_comb begin
		// all four failure causes count while enabled, whatever the shutdown enables say
		sup_fault  = sup_overcurrent | sup_overvoltage | sup_undervoltage
		           | thermal_shutdown_level_one;
		glass_mode = st_q.glass_control_enable;
		// own settings of the supply output, used only outside glass mode
		own_output = st_q.supcfg[ecg_pkg::SUP_PWM_BIT] ? sup_pwm_in
		           : st_q.supcfg[ecg_pkg::SUP_ON_BIT];

		st_d       = st_q;
		st_d.rdata = 32'h0000_0000;

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				ecg_pkg::OFS_CTRL: begin
					st_d.glass_target_code         = reg_wdata[ecg_pkg::CTRL_CODE_LSB +: 6];
					st_d.glass_control_enable      = reg_wdata[ecg_pkg::CTRL_EN_BIT];
					st_d.fast_discharge_sel        = reg_wdata[ecg_pkg::CTRL_LS_BIT];
					st_d.high_voltage_range_select = reg_wdata[ecg_pkg::CTRL_HV_BIT];
				end
				ecg_pkg::OFS_SUPCFG: st_d.supcfg = reg_wdata[7:0];
				ecg_pkg::OFS_IRQ:    st_d.sticky = st_q.sticky & ~reg_wdata[ecg_pkg::EV_W-1:0];
				ecg_pkg::OFS_MASK:   st_d.mask   = reg_wdata[ecg_pkg::EV_W-1:0];
				default: ;
			endcase
		end

		// reads; reading the failure register clears the latch
		if (reg_rd) begin
			st_d.rdata = read_word(st_q, reg_addr, above_if.flag, below_if.flag);
			if (reg_addr == ecg_pkg::OFS_FAIL) begin
				st_d.failed = 1'b0;
			end
		end

		// automatic restart when the lock is disabled and the fault is gone
		if (!st_q.supcfg[ecg_pkg::SUP_LOCK_BIT] && !sup_fault) begin
			st_d.failed = 1'b0;
		end

		// a failure during glass control wins over any clear in the same cycle;
		// enable and discharge select are left untouched
		if (glass_mode && sup_fault) begin
			st_d.failed            = 1'b1;
			st_d.glass_target_code = 6'h00;
		end

		// fast discharge runs until the pin is inside the margin above target
		if (st_d.fast_discharge_sel && !st_q.fast_discharge_sel) begin
			st_d.ls_active = 1'b1;
		end
		if (!st_d.fast_discharge_sel || cmp_within_margin) begin
			st_d.ls_active = 1'b0;
		end

		// sticky events: set beats a same-cycle write-one clear
		if (above_if.rise) begin
			st_d.sticky[ecg_pkg::EV_ABOVE] = 1'b1;
		end
		if (below_if.rise) begin
			st_d.sticky[ecg_pkg::EV_BELOW] = 1'b1;
		end
		if (glass_mode && sup_fault && !st_q.failed) begin
			st_d.sticky[ecg_pkg::EV_FAIL] = 1'b1;
		end

		// output images, every one registered
		st_d.dac     = clamp_code(st_d.glass_target_code,
		                          st_d.high_voltage_range_select);
		st_d.loop_en = st_d.glass_control_enable && !st_d.failed
		             && !sup_fault;
		st_d.ls_out  = st_d.ls_active;
		st_d.gate_res = !st_d.glass_control_enable;
		st_d.gate_gnd = st_d.glass_control_enable && st_d.failed;
		if (st_d.glass_control_enable) begin
			// forced on unless failed or faulted; own pwm, direction and timer ignored
			st_d.sup_out = !st_d.failed && !sup_fault;
		end else begin
			// own settings take over again as soon as the enable drops
			st_d.sup_out = own_output;
		end
		st_d.above = above_if.flag;
		st_d.below = below_if.flag;
		st_d.irq   = |(st_d.sticky & st_d.mask);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q                           <= '0;
			st_q.glass_target_code         <= ecg_pkg::CTRL_RST[5:0];
			st_q.supcfg                    <= ecg_pkg::SUPCFG_RST;
			st_q.gate_res                  <= 1'b1; // gate held low from reset
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata                = st_q.rdata;
	assign glass_dac_code           = st_q.dac;
	assign loop_enable              = st_q.loop_en;
	assign fast_discharge_switch_on = st_q.ls_out;
	assign gate_pin_discharge_on    = st_q.gate_res;
	assign gate_pin_hard_ground     = st_q.gate_gnd;
	assign glass_supply_output      = st_q.sup_out;
	assign above_target_flag        = st_q.above;
	assign below_target_flag        = st_q.below;
	assign irq                      = st_q.irq;
endmodule : ecg_ctrl

// [test/ecg_props.sv]
/* ecg_props: port-level assertions for the glass controller.
   Assumes one clock domain and the filter times of ecg_pkg. */
module ecg_props (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       cmp_above,
	input wire logic       cmp_below,
	input wire logic       cmp_within_margin,
	input wire logic       sup_overcurrent,
	input wire logic       sup_overvoltage,
	input wire logic       sup_undervoltage,
	input wire logic       thermal_shutdown_level_one,
	input wire logic [5:0] glass_dac_code,
	input wire logic       loop_enable,
	input wire logic       fast_discharge_switch_on,
	input wire logic       gate_pin_discharge_on,
	input wire logic       gate_pin_hard_ground,
	input wire logic       glass_supply_output,
	input wire logic       above_target_flag,
	input wire logic       below_target_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] above_run_q;
	logic [11:0] below_run_q;
	// runs of each raw level; saturate so a long level never wraps to a small count
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			above_run_q <= 12'h000;
			below_run_q <= 12'h000;
		end else begin
			above_run_q <= !cmp_above ? 12'h000 : above_run_q + 12'((~&above_run_q));
			below_run_q <= !cmp_below ? 12'h000 : below_run_q + 12'((~&below_run_q));
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_gate_pull_off: assert property (gate_pin_discharge_on |-> !loop_enable)
		else $error("gate pin pulled while loop runs");
	a_oc_loop_off: assert property (loop_enable && sup_overcurrent
		|=> !loop_enable && !glass_supply_output)
		else $error("overcurrent left loop on");
	a_fault_out_off: assert property (loop_enable && (sup_overvoltage
		|| sup_undervoltage || thermal_shutdown_level_one) |=> !glass_supply_output)
		else $error("supply fault left output on");
	a_fault_ground: assert property (loop_enable && sup_overcurrent
		|-> ##[1:3] gate_pin_hard_ground)
		else $error("gate pin not grounded after fault");
	a_fail_code_zero: assert property ($rose(gate_pin_hard_ground)
		|-> ##[0:2] glass_dac_code == 6'h00)
		else $error("target code kept after fault");
	a_above_filter: assert property ($rose(above_target_flag)
		|-> above_run_q >= ecg_pkg::ABOVE_FILTER_CYC)
		else $error("above flag set before filter time");
	a_below_filter: assert property ($rose(below_target_flag)
		|-> below_run_q >= ecg_pkg::BELOW_FILTER_CYC)
		else $error("below flag set before filter time");
	a_glass_supply_on: assert property (loop_enable |-> glass_supply_output)
		else $error("supply output off in glass mode");
	a_discharge_stop: assert property (fast_discharge_switch_on && cmp_within_margin
		|-> ##[1:2] !fast_discharge_switch_on)
		else $error("discharge kept past margin");
endmodule : ecg_props

bind ecg_ctrl ecg_props ecg_props_inst (.sys_clk, .rst_n, .cmp_above, .cmp_below,
	.cmp_within_margin, .sup_overcurrent, .sup_overvoltage, .sup_undervoltage,
	.thermal_shutdown_level_one, .glass_dac_code, .loop_enable, .fast_discharge_switch_on,
	.gate_pin_discharge_on, .gate_pin_hard_ground, .glass_supply_output, .above_target_flag,
	.below_target_flag);

// [test/ecg_glass_model.sv]
/* ecg_glass_model: glass element and follower as a pin level in code steps.
   Assumes the bench loads the settled level; discharge drops one step a cycle. */
module ecg_glass_model #(
	parameter int unsigned MARGIN = 2
) (
	input  wire logic       sys_clk,
	input  wire logic       load,
	input  wire logic [6:0] pin_set,
	input  wire logic [5:0] glass_dac_code,
	input  wire logic       fast_discharge_switch_on,
	output logic      [6:0] pin_lvl = 7'h00,
	output logic            cmp_above,
	output logic            cmp_below,
	output logic            cmp_within_margin
);
	timeunit 1ns;
	timeprecision 1ns;
	// the low-side switch drains the element; a load from the bench overrides it
	always @(posedge sys_clk) begin
		if (load) pin_lvl <= pin_set;
		else if (fast_discharge_switch_on && pin_lvl != 7'h00) pin_lvl <= pin_lvl - 7'h01;
	end
	// comparators against the target; margin lies above the target
	assign cmp_above = pin_lvl > {1'b0, glass_dac_code};
	assign cmp_below = pin_lvl < {1'b0, glass_dac_code};
	assign cmp_within_margin = pin_lvl <= {1'b0, glass_dac_code} + 7'(MARGIN);
endmodule : ecg_glass_model

// [test/electrochromic_glass_control_tb_top.sv]
/* electrochromic_glass_control_tb_top: register-level bench for the glass controller.
   Assumes ecg_pkg, ecg_ctrl, the checker and the glass model are compiled first. */
module electrochromic_glass_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, load = 1'b0;
	logic [3:0]  reg_addr = 4'h0, flt = 4'h0; // flt: oc, ov, uv, thermal
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [6:0]  pin_set = 7'h00, pin_lvl;
	logic [5:0]  glass_dac_code;
	logic        cmp_above, cmp_below, cmp_within_margin, loop_enable, fast_discharge_switch_on;
	logic        gate_pin_discharge_on, gate_pin_hard_ground, glass_supply_output, irq;
	logic        above_target_flag, below_target_flag;
	logic        sup_pwm = 1'b0; // own pwm level of the supply output
	int          miscompares = 0, check_count = 0, cyc_cnt = 0;

	always #20 sys_clk = ~sys_clk;
	ecg_ctrl ecg_ctrl_inst (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.cmp_above, .cmp_below, .cmp_within_margin, .sup_overcurrent(flt[0]),
		.sup_overvoltage(flt[1]), .sup_undervoltage(flt[2]), .thermal_shutdown_level_one(flt[3]),
		.sup_pwm_in(sup_pwm), .glass_dac_code, .loop_enable, .fast_discharge_switch_on,
		.gate_pin_discharge_on, .gate_pin_hard_ground, .glass_supply_output,
		.above_target_flag, .below_target_flag, .irq);
	ecg_glass_model ecg_glass_model_inst (.sys_clk, .load, .pin_set, .glass_dac_code,
		.fast_discharge_switch_on, .pin_lvl, .cmp_above, .cmp_below, .cmp_within_margin);

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// the trailing #1 lets the edge's updates land before anything is sampled
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rd
	task automatic pin(input logic [6:0] v);
		@(posedge sys_clk);
		{pin_set, load} <= {v, 1'b1};
		@(posedge sys_clk);
		load <= 1'b0;
	endtask : pin
	task automatic fault(input logic [3:0] f);
		@(posedge sys_clk);
		flt <= f;
		// release on the edge itself, so the fault inputs only move at rising edges
		repeat (3) @(posedge sys_clk);
		flt <= 4'h0;
		cyc(3);
	endtask : fault

	// hang guard: the run needs under 5000 cycles
	always @(posedge sys_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			miscompares++;
			wrap_up;
		end
	end

	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		cyc(1);
		chk({gate_pin_discharge_on, loop_enable}, 2'b10);
		rd(ecg_pkg::OFS_SUPCFG, 32'h80);
		rd(4'hf, 32'h0);
		// own settings pwm and on, so a pwm-driven output would be low here
		wr(ecg_pkg::OFS_SUPCFG, 32'h83);
		pin(7'h3f);
		wr(ecg_pkg::OFS_CTRL, 32'h13f);
		cyc(2);
		chk(glass_dac_code, 6'h33);
		wr(ecg_pkg::OFS_CTRL, 32'h53f);
		cyc(2);
		chk({glass_dac_code, loop_enable}, {6'h3f, 1'b1});
		chk({glass_supply_output, gate_pin_discharge_on}, 2'b10);
		// filtered flags, sticky bits and the mask
		wr(ecg_pkg::OFS_CTRL, 32'h515);
		wr(ecg_pkg::OFS_IRQ, 32'h7);
		wr(ecg_pkg::OFS_MASK, 32'h1);
		pin(7'h20);
		cyc(1590);
		chk(above_target_flag, 1'b0);
		cyc(20);
		chk({above_target_flag, below_target_flag, irq}, 3'b101);
		rd(ecg_pkg::OFS_IRQ, 32'h1);
		wr(ecg_pkg::OFS_IRQ, 32'h1);
		cyc(2);
		chk(irq, 1'b0);
		pin(7'h10);
		cyc(1610);
		chk({above_target_flag, below_target_flag, irq}, 3'b010);
		rd(ecg_pkg::OFS_STAT, 32'h2);
		rd(ecg_pkg::OFS_IRQ, 32'h2);
		// fast discharge from well above the target
		pin(7'h3f);
		wr(ecg_pkg::OFS_CTRL, 32'h715);
		cyc(1);
		chk(fast_discharge_switch_on, 1'b1);
		for (int i = 0; i < 200 && fast_discharge_switch_on !== 1'b0; i++) cyc(1);
		chk(pin_lvl inside {[7'h14:7'h17]}, 1'b1);
		// each supply failure kind, with the lock set: manual restart
		for (int i = 0; i < 4; i++) begin
			wr(ecg_pkg::OFS_CTRL, 32'h72a);
			cyc(2);
			chk({glass_dac_code, glass_supply_output}, {6'h2a, 1'b1});
			fault(4'h1 << i);
			chk({glass_supply_output, gate_pin_hard_ground, glass_dac_code},
			    8'h40);
			rd(ecg_pkg::OFS_CTRL, 32'h700);
			rd(ecg_pkg::OFS_FAIL, 32'h1);
			cyc(2);
			chk(gate_pin_hard_ground, 1'b0);
		end
		// lock cleared: restart without a read, then the code is rewritten
		wr(ecg_pkg::OFS_SUPCFG, 32'h01);
		fault(4'h2);
		chk(gate_pin_hard_ground, 1'b0);
		wr(ecg_pkg::OFS_CTRL, 32'h52a);
		cyc(2);
		chk({glass_dac_code, glass_supply_output}, {6'h2a, 1'b1});
		wr(ecg_pkg::OFS_CTRL, 32'h0);
		cyc(2);
		chk({loop_enable, glass_supply_output, gate_pin_discharge_on}, 3'b011);
		wr(ecg_pkg::OFS_SUPCFG, 32'h0);
		cyc(2);
		chk(glass_supply_output, 1'b0);
		// own pwm select again: outside glass mode the output follows the pwm level
		wr(ecg_pkg::OFS_SUPCFG, 32'h02);
		sup_pwm <= 1'b1;
		cyc(2);
		chk(glass_supply_output, 1'b1);
		wrap_up;
	end
endmodule : electrochromic_glass_control_tb_top
